// [printer_port_registers.sv]
`timescale 1ns/10ps

// Notes on behaviour
// R1 - Compatibility mode: write drives lines, read returns latch.
// R2 - Extended mode: read latch, or lines when direction set.
// R3 - Extended writes always latch; drive only direction clear.
// R4 - Direction bit 5 acts only in extended mode.
// R5 - Direction set disables drivers; clear restores output.
// R6 - Data index 0, status 1, control 2.
// R7 - Status bits 0 and 1 read one.
// R8 - Flag clears on acknowledge release while bit 4 set; status read sets.
// R9 - Status 3..7: error, select, paper, ack, busy.
// R10 - After reset status 0..2 read one.
// R11 - Control read returns last write.
// R12 - Control bit 0 drives strobe output.
// R13 - Control bit 1 drives autofeed output.
// R14 - Control bit 2 set negates initialize output.
// R15 - Control bit 3 drives select-in output.
// R16 - Bit 4 enables interrupt; clear floats output.
// R17 - Control bits 6 and 7 read zero.
// R18 - Interrupt active while flag cleared and enabled.
module printer_port_registers (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Avalon-MM slave.
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Printer connector; assertion levels are active high at these ports.
  input  wire logic        extended_mode_pin,
  input  wire logic [7:0] printer_data_lines_in,
  output logic      [7:0] printer_data_lines_out,
  output logic            printer_data_lines_oe,
  input  wire logic        errorInput,
  input  wire logic        selected_input,
  input  wire logic        paper_out_input,
  input  wire logic        ackInput,
  input  wire logic        busyInput,
  output logic             strobe_ctrl,
  output logic             autofeed_ctrl,
  output logic             initOut,
  output logic             select_in_ctrl,
  output logic             printer_irq_out,
  output logic             printer_irq_out_oe
);

  // ---------------------------------------------------------------------------
  // Register state.
  // ---------------------------------------------------------------------------
  logic [7:0] dataLatch;
  logic [5:0] printer_control_reg;
  logic       irqFlag;        // Active low: zero means an acknowledge was seen.
  logic       ackLast;
  logic       busy;           // Request accepted, answer due next edge.
  logic       doRead;
  logic       doWrite;
  logic       wordSel;
  logic [7:0] printer_status_reg;
  logic [7:0] dataReadValue;
  logic       dirActive;
  logic       statusRead;
  logic       ackRelease;

  // ---------------------------------------------------------------------------
  // Bus handshake.
  // ---------------------------------------------------------------------------

  // Every access waits one cycle so read data come from a flop; the access
  // takes effect at the edge where waitrequest is sampled low.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      busy <= 1'b0;
    end else if (busy) begin
      busy <= 1'b0;
    end else if (read || write) begin
      busy <= 1'b1;
    end
  end

  // Waitrequest idles high and drops for exactly the completing cycle.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~(~busy && (read || write));
    end
  end

  // Strobes fire on the completing edge only, once per access.
  assign doRead  = read && ~waitrequest;
  assign doWrite = write && ~waitrequest && byteenable[0];
  assign wordSel = (address[3:2] == 2'h0);

  // ---------------------------------------------------------------------------
  // Data path and direction.
  // ---------------------------------------------------------------------------

  // Direction only counts in extended mode.
  assign dirActive = extended_mode_pin && printer_control_reg[printer_port_pkg::CTL_DIR]; // R4

  // Writes always land in the latch, in either mode.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dataLatch <= printer_port_pkg::DATA_RESET;
    end else if (doWrite && wordSel && address[1:0] == printer_port_pkg::IDX_DATA) begin
      dataLatch <= writedata[7:0]; // R1 R3
    end
  end

  // The drivers follow the latch with one register stage so the pins come
  // straight from flops; a write reaches the pins one edge after it completes.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      printer_data_lines_out <= printer_port_pkg::DATA_RESET;
      printer_data_lines_oe  <= 1'b1;
    end else begin
      printer_data_lines_out <= dataLatch; // R1
      printer_data_lines_oe  <= ~dirActive; // R3 R5
    end
  end

  assign dataReadValue = dirActive ? printer_data_lines_in : dataLatch; // R2

  // ---------------------------------------------------------------------------
  // Control register and printer control outputs.
  // ---------------------------------------------------------------------------

  // Control holds the last written value of its six live bits.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      printer_control_reg <= printer_port_pkg::CONTROL_RESET;
    end else if (doWrite && wordSel && address[1:0] == printer_port_pkg::IDX_CONTROL) begin
      printer_control_reg <= writedata[5:0]; // R11
    end
  end

  // Control outputs are registered copies of the control bits; initOut takes the inverse of its bit.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      strobe_ctrl    <= 1'b0;
      autofeed_ctrl  <= 1'b0;
      initOut        <= 1'b1;
      select_in_ctrl <= 1'b0;
    end else begin
      strobe_ctrl    <= printer_control_reg[printer_port_pkg::CTL_STROBE]; // R12
      autofeed_ctrl  <= printer_control_reg[printer_port_pkg::CTL_AUTOFEED]; // R13
      initOut        <= ~printer_control_reg[printer_port_pkg::CTL_INIT]; // R14
      select_in_ctrl <= printer_control_reg[printer_port_pkg::CTL_SELECT_IN]; // R15
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt flag.
  // ---------------------------------------------------------------------------
  assign statusRead = doRead && wordSel && address[1:0] == printer_port_pkg::IDX_STATUS;
  assign ackRelease = ackLast && ~ackInput;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ackLast <= 1'b0;
    end else begin
      ackLast <= ackInput;
    end
  end

  // The acknowledge event wins over a status read completing in the same cycle, so that read
  // cannot lose it; the read returns the pre-event value in that cycle.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irqFlag <= 1'b1; // R10
    end else if (ackRelease && printer_control_reg[printer_port_pkg::CTL_IRQ_EN]) begin
      irqFlag <= 1'b0; // R8
    end else if (statusRead) begin
      irqFlag <= 1'b1; // R8
    end
  end

  // Output floats while disabled; drives active while the flag is cleared.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      printer_irq_out    <= 1'b0;
      printer_irq_out_oe <= 1'b0;
    end else begin
      printer_irq_out    <= ~irqFlag && printer_control_reg[printer_port_pkg::CTL_IRQ_EN]; // R18
      printer_irq_out_oe <= printer_control_reg[printer_port_pkg::CTL_IRQ_EN]; // R16
    end
  end

  // ---------------------------------------------------------------------------
  // Read multiplexer.
  // ---------------------------------------------------------------------------
  assign printer_status_reg = {busyInput, ackInput, paper_out_input, selected_input, errorInput,
                               irqFlag, printer_port_pkg::STS_RESERVED}; // R7 R9

  // Data is captured into readdata when the request is accepted, one edge before the completing edge.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      readdata <= printer_port_pkg::UNMAPPED_READ;
    end else if (~busy && read) begin
      if (!wordSel) begin
        readdata <= printer_port_pkg::UNMAPPED_READ;
      end else begin
        unique case (address[1:0])
          printer_port_pkg::IDX_DATA:    readdata <= {24'h000000, dataReadValue}; // R6
          printer_port_pkg::IDX_STATUS:  readdata <= {24'h000000, printer_status_reg}; // R6
          printer_port_pkg::IDX_CONTROL: readdata <= {24'h000000, printer_port_pkg::CTL_RESERVED,
                                                      printer_control_reg}; // R17
          default:                       readdata <= printer_port_pkg::UNMAPPED_READ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------
  sequence s_ackFall;
    $fell(ackInput) && printer_control_reg[printer_port_pkg::CTL_IRQ_EN];
  endsequence

  property p_irqClear;
    @(posedge clk_sys) disable iff (reset)
      s_ackFall |=> !irqFlag ##1 (printer_irq_out && printer_irq_out_oe);
  endproperty
  a_irqClear: assert property (p_irqClear) else $error("ack release did not raise interrupt"); // R8

  property p_readSets;
    @(posedge clk_sys) disable iff (reset)
      (statusRead && !ackRelease) |=> irqFlag;
  endproperty
  a_readSets: assert property (p_readSets) else $error("status read did not set flag"); // R8

  property p_noDriveDir;
    @(posedge clk_sys) disable iff (reset)
      (extended_mode_pin && printer_control_reg[printer_port_pkg::CTL_DIR]) |=> !printer_data_lines_oe;
  endproperty
  a_noDriveDir: assert property (p_noDriveDir) else $error("drivers on in input direction"); // R5

  property p_compatDrive;
    @(posedge clk_sys) disable iff (reset)
      !extended_mode_pin |=> printer_data_lines_oe;
  endproperty
  a_compatDrive: assert property (p_compatDrive) else $error("drivers off in compatibility mode"); // R4

  property p_dataOut;
    @(posedge clk_sys) disable iff (reset)
      (doWrite && wordSel && address[1:0] == printer_port_pkg::IDX_DATA) |=> ##1
        printer_data_lines_out == $past(writedata[7:0], 2);
  endproperty
  a_dataOut: assert property (p_dataOut) else $error("written byte not on data lines"); // R1

  property p_statusRead;
    @(posedge clk_sys) disable iff (reset)
      statusRead |-> readdata[1:0] == 2'h3 && readdata[7:3] == $past({busyInput, ackInput,
        paper_out_input, selected_input, errorInput});
  endproperty
  a_statusRead: assert property (p_statusRead) else $error("status read value wrong"); // R9

  property p_ctlReserved;
    @(posedge clk_sys) disable iff (reset)
      (doRead && wordSel && address[1:0] == printer_port_pkg::IDX_CONTROL) |->
        readdata[7:0] == {2'h0, $past(printer_control_reg)};
  endproperty
  a_ctlReserved: assert property (p_ctlReserved) else $error("control read value wrong"); // R17

  property p_initInv;
    @(posedge clk_sys) disable iff (reset)
      $rose(printer_control_reg[printer_port_pkg::CTL_INIT]) |=> !initOut;
  endproperty
  a_initInv: assert property (p_initInv) else $error("initialize output not negated"); // R14

  property p_strobe;
    @(posedge clk_sys) disable iff (reset)
      ##1 strobe_ctrl == $past(printer_control_reg[printer_port_pkg::CTL_STROBE]);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe does not follow control"); // R12

  property p_wait;
    @(posedge clk_sys) disable iff (reset)
      $rose(read || write) |-> ##[1:2] !waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus access not answered"); // R6

  // ---------------------------------------------------------------------------
  // Register writes, read paths and reset state.
  // ---------------------------------------------------------------------------

  // A control write completes at the edge where waitrequest is sampled low.
  sequence s_ctlWrite;
    doWrite && wordSel && address[1:0] == printer_port_pkg::IDX_CONTROL;
  endsequence

  // Data reads split on the direction seen when readdata was captured, one
  // edge before the completing edge.
  sequence s_latchRead;
    doRead && wordSel && address[1:0] == printer_port_pkg::IDX_DATA && !$past(dirActive);
  endsequence

  sequence s_lineRead;
    doRead && wordSel && address[1:0] == printer_port_pkg::IDX_DATA && $past(dirActive);
  endsequence

  property p_ctlWrite;
    @(posedge clk_sys) disable iff (reset)
      s_ctlWrite |=> printer_control_reg == $past(writedata[5:0]);
  endproperty
  a_ctlWrite: assert property (p_ctlWrite) else $error("control write did not land"); // R11

  // The pins trail the register by one more edge, so the byte is two edges old.
  property p_ctlOutputs;
    @(posedge clk_sys) disable iff (reset)
      s_ctlWrite |=> ##1 (autofeed_ctrl == $past(writedata[printer_port_pkg::CTL_AUTOFEED], 2) &&
                          select_in_ctrl == $past(writedata[printer_port_pkg::CTL_SELECT_IN], 2));
  endproperty
  a_ctlOutputs: assert property (p_ctlOutputs) else $error("control outputs do not follow write"); // R13 R15

  property p_irqOe;
    @(posedge clk_sys) disable iff (reset)
      s_ctlWrite |=> ##1 printer_irq_out_oe == $past(writedata[printer_port_pkg::CTL_IRQ_EN], 2);
  endproperty
  a_irqOe: assert property (p_irqOe) else $error("interrupt enable not on output enable"); // R16

  // With the enable clear the pin floats and no stale active level is left.
  property p_irqQuiet;
    @(posedge clk_sys) disable iff (reset)
      !printer_control_reg[printer_port_pkg::CTL_IRQ_EN] |=> !printer_irq_out && !printer_irq_out_oe;
  endproperty
  a_irqQuiet: assert property (p_irqQuiet) else $error("interrupt output active while disabled"); // R16 R18

  // A release seen while disabled must not clear the flag behind the host's back.
  property p_noClearOff;
    @(posedge clk_sys) disable iff (reset)
      (ackRelease && !printer_control_reg[printer_port_pkg::CTL_IRQ_EN] && !statusRead) |=> $stable(irqFlag);
  endproperty
  a_noClearOff: assert property (p_noClearOff) else $error("flag cleared while disabled"); // R8

  property p_latchRead;
    @(posedge clk_sys) disable iff (reset)
      s_latchRead |-> readdata[7:0] == $past(dataLatch);
  endproperty
  a_latchRead: assert property (p_latchRead) else $error("data read did not return latch"); // R1 R2

  property p_lineRead;
    @(posedge clk_sys) disable iff (reset)
      s_lineRead |-> readdata[7:0] == $past(printer_data_lines_in);
  endproperty
  a_lineRead: assert property (p_lineRead) else $error("data read did not return lines"); // R2

  // Only the low byte carries a register, so the rest of the word reads zero.
  property p_upperZero;
    @(posedge clk_sys) disable iff (reset)
      doRead |-> readdata[31:8] == 24'h000000;
  endproperty
  a_upperZero: assert property (p_upperZero) else $error("upper read bits not zero"); // R6

  // A single low cycle keeps one request from completing twice.
  property p_oneWait;
    @(posedge clk_sys) disable iff (reset)
      !waitrequest |=> waitrequest;
  endproperty
  a_oneWait: assert property (p_oneWait) else $error("waitrequest low for two cycles"); // R6

  // First edge after reset: flag set, drivers on, initialize asserted, bus idle.
  property p_resetState;
    @(posedge clk_sys) disable iff (reset)
      $fell(reset) |-> irqFlag && waitrequest && printer_data_lines_oe && initOut;
  endproperty
  a_resetState: assert property (p_resetState) else $error("state after reset wrong"); // R10

endmodule // printer_port_registers

// [printer_port_pkg.sv]
package printer_port_pkg;

  // ---------------------------------------------------------------------------
  // Register map: the index sits in the low two address bits; the upper two must be zero.
  // ---------------------------------------------------------------------------
  localparam logic [1:0] IDX_DATA    = 2'h0;
  localparam logic [1:0] IDX_STATUS  = 2'h1;
  localparam logic [1:0] IDX_CONTROL = 2'h2;

  // ---------------------------------------------------------------------------
  // Control register field positions.
  // ---------------------------------------------------------------------------
  localparam int CTL_STROBE    = 0;
  localparam int CTL_AUTOFEED  = 1;
  localparam int CTL_INIT      = 2;
  localparam int CTL_SELECT_IN = 3;
  localparam int CTL_IRQ_EN    = 4;
  localparam int CTL_DIR       = 5;

  // ---------------------------------------------------------------------------
  // Status register field positions.
  // ---------------------------------------------------------------------------
  localparam int STS_IRQ_FLAG  = 2;
  localparam int STS_ACK       = 6;

  // ---------------------------------------------------------------------------
  // Reset values and fixed bit patterns.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] DATA_RESET     = 8'h00;
  localparam logic [5:0] CONTROL_RESET  = 6'h00;
  localparam logic [1:0] STS_RESERVED   = 2'h3;
  localparam logic [1:0] CTL_RESERVED   = 2'h0;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Bus answer timing: cycles from request to waitrequest low.
  // ---------------------------------------------------------------------------
  localparam int BUS_WAIT_CYCLES = 1;

endpackage

// [printer_model.sv]
`timescale 1ns/10ps

// ---------------------------------------------------------------------------
// Printer standing on the far side of the connector.
// ---------------------------------------------------------------------------
module printer_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] hostByte,
  input  wire logic       hostDrive,
  output logic      [7:0] lineLevel,
  output logic      [4:0] statusLines
);
  logic       peerDrive = 1'b0;
  logic [7:0] peerByte  = 8'h00;
  logic [7:0] lastLevel = 8'h00;

  // The lines have no pull-up, so a released bus toggles instead of keeping a stale byte.
  always_comb lineLevel = hostDrive ? hostByte : (peerDrive ? peerByte : ~lastLevel);

  // Last level seen, used to make the floating pattern.
  always_ff @(posedge clk_sys) lastLevel <= lineLevel;

  // Status inputs idle low: no error, not selected, paper present, no ack, not busy.
  initial statusLines = 5'h00;

  task automatic present(input logic on, input logic [7:0] b);
    @(posedge clk_sys);
    peerDrive <= on;
    peerByte  <= b;
  endtask

  task automatic set_status(input logic [4:0] s);
    @(posedge clk_sys);
    statusLines <= s;
  endtask

  // Acknowledge held active for a few cycles, then released.
  task automatic pulse_ack();
    @(posedge clk_sys);
    statusLines[3] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    statusLines[3] <= 1'b0;
  endtask
endmodule // printer_model

// [tb_top.sv]
`timescale 1ns/10ps

module tb_top;
  localparam logic [3:0] A_DAT = {2'h0, printer_port_pkg::IDX_DATA};
  localparam logic [3:0] A_STS = {2'h0, printer_port_pkg::IDX_STATUS};
  localparam logic [3:0] A_CTL = {2'h0, printer_port_pkg::IDX_CONTROL};
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'hF;
  logic        extendedMode = 1'b0;
  logic [31:0] readdata, q;
  logic [7:0]  lineLevel, dataOut;
  logic [4:0]  st;
  logic        waitrequest, dataOe, strobe, autofeed, initOut, selectIn, irqOut, irqOe;
  int          errors = 0;
  int          num_checks = 0;

  // Free-running system clock.
  initial forever #4 clk_sys = ~clk_sys;

  printer_port_registers u_dut (.clk_sys(clk_sys), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .extended_mode_pin(extendedMode), .printer_data_lines_in(lineLevel),
    .printer_data_lines_out(dataOut), .printer_data_lines_oe(dataOe), .errorInput(st[0]),
    .selected_input(st[1]), .paper_out_input(st[2]), .ackInput(st[3]), .busyInput(st[4]),
    .strobe_ctrl(strobe), .autofeed_ctrl(autofeed), .initOut(initOut), .select_in_ctrl(selectIn),
    .printer_irq_out(irqOut), .printer_irq_out_oe(irqOe));

  printer_model u_prn (.clk_sys(clk_sys), .hostByte(dataOut), .hostDrive(dataOe),
    .lineLevel(lineLevel), .statusLines(st));

  // ---------------------------------------------------------------------------
  // Shared tasks.
  // ---------------------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One bus access; the request stands until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= {24'h0, d};
    byteenable <= be;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      errors++;
      finish_test();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  // Reads and compares the whole word; the upper bytes must be zero.
  task automatic rd(input string name, input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    check(name, q, {24'h0, e});
  endtask

  // Lets a write reach the connector outputs.
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------------
  task automatic t_reset_status();
    rd("data", A_DAT, printer_port_pkg::DATA_RESET);
    rd("control", A_CTL, 8'h00);
    rd("status", A_STS, 8'h07);
    for (int i = 0; i < 5; i++) begin
      u_prn.set_status(5'h01 << i);
      rd("status", A_STS, {5'h01 << i, 3'h7});
    end
    u_prn.set_status(5'h00);
  endtask

  task automatic t_compat();
    wr(A_DAT, 8'hA5);
    settle();
    check("lines", {dataOe, dataOut}, 9'h1A5);
    rd("data", A_DAT, 8'hA5);
    wr(A_CTL, 8'h20);
    u_prn.present(1'b1, 8'h3C);
    settle();
    check("oe", dataOe, 1'b1);
    rd("data", A_DAT, 8'hA5);
    u_prn.present(1'b0, 8'h00);
    wr(A_CTL, 8'h00);
  endtask

  task automatic t_extended();
    extendedMode <= 1'b1;
    wr(A_DAT, 8'h5A);
    u_prn.present(1'b1, 8'hC3);
    rd("data", A_DAT, 8'h5A);
    wr(A_CTL, 8'h20);
    settle();
    check("oe", dataOe, 1'b0);
    rd("data", A_DAT, 8'hC3);
    wr(A_DAT, 8'h96);
    settle();
    check("oe", dataOe, 1'b0);
    u_prn.present(1'b0, 8'h00);
    wr(A_CTL, 8'h00);
    settle();
    check("lines", {dataOe, lineLevel}, 9'h196);
    rd("data", A_DAT, 8'h96);
    extendedMode <= 1'b0;
  endtask

  // Each live control bit alone, bits 6 and 7 together, then all set; bits 6 and 7 never read back.
  task automatic t_control();
    logic [7:0] tab [9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'hC0, 8'hFF, 8'h00};
    foreach (tab[i]) begin
      wr(A_CTL, tab[i]);
      settle();
      rd("control", A_CTL, tab[i] & 8'h3F);
      check("strobe", strobe, tab[i][0]);
      check("autofeed", autofeed, tab[i][1]);
      check("init", initOut, !tab[i][2]);
      check("selectIn", selectIn, tab[i][3]);
      check("irqOe", irqOe, tab[i][4]);
    end
  endtask

  task automatic t_irq();
    wr(A_CTL, 8'h10);
    settle();
    check("irq", {irqOe, irqOut}, 2'b10);
    u_prn.pulse_ack();
    settle();
    check("irq", irqOut, 1'b1);
    rd("status", A_STS, 8'h03);
    rd("status", A_STS, 8'h07);
    settle();
    check("irq", irqOut, 1'b0);
    wr(A_CTL, 8'h00);
    u_prn.pulse_ack();
    settle();
    check("irqOe", irqOe, 1'b0);
    rd("status", A_STS, 8'h07);
  endtask

  // Unmapped places and disabled byte lanes change nothing.
  task automatic t_refused();
    wr(A_DAT, 8'h11);
    wr(4'h4, 8'hEE);
    bus(1'b1, A_DAT, 8'h77, 4'hE);
    rd("data", A_DAT, 8'h11);
    rd("unmapped", 4'h3, 8'h00);
    wr(A_STS, 8'h00);
    rd("status", A_STS, 8'h07);
  endtask

  // Reset in mid-run: everything written before returns to its reset state.
  task automatic t_midreset();
    wr(A_DAT, 8'h3C);
    wr(A_CTL, 8'h1F);
    settle();
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("reset pins", {strobe, autofeed, initOut, selectIn, irqOe, irqOut, dataOe, waitrequest}, 8'h23);
    check("reset lines", dataOut, printer_port_pkg::DATA_RESET);
    rd("data", A_DAT, printer_port_pkg::DATA_RESET);
    rd("control", A_CTL, 8'h00);
    rd("status", A_STS, 8'h07);
  endtask

  // Main sequence: reset for five cycles, then every scenario in turn.
  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset_status();
    t_compat();
    t_extended();
    t_control();
    t_irq();
    t_refused();
    t_midreset();
    finish_test();
  end
endmodule // tb_top
